// ==== rtl/i2tp_pkg.sv ====
// Package for the two-wire target port: constants, types and behaviour list
// Behaviour
// - Acknowledge address only when it matches target
// - Target address resets to 1001000
// - Only low three address bits are programmable
// - Direction bit 0 writes, 1 reads
// - Works at any clock up to 400kHz
// - Bare address probe is acknowledged on match
// - Every byte acknowledged by its receiver
// - Write: address, pointer byte, then data bytes
// - Device drives data from read-address acknowledge
// - No-acknowledge makes device release data line
// - Pointer advances after each written byte
// - Writes past FFh are discarded
// - Read-only or reserved writes dropped, pointer advances
// - Short or unacknowledged bytes never committed
// - Read bytes msb first, pointer then advances
// - Reads past FFh return FFh
// - Reserved addresses may read anything
// - Two-byte register latched on high-byte read
// - Low address bits from status bits 2:0
// - Acknowledge holds data low over ninth clock
package i2tp_pkg;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [3:0] SA_HI = 4'h9;
  localparam logic [2:0] SA_LO_RST = 3'h0;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h0a;
  localparam logic [7:0] ADDR_VOLT_HI = 8'h0c;
  localparam logic [7:0] ADDR_CURR_HI = 8'h0e;
  localparam logic [7:0] ADDR_ACC_HI = 8'h10;
  localparam logic [7:0] ADDR_ACC_LO = 8'h11;
  localparam logic [7:0] ADDR_OFFS_BIAS = 8'h61;
  localparam logic [7:0] ADDR_ACC_BIAS = 8'h62;
  localparam logic [7:0] ADDR_LAST = 8'hff;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ----------------------------------------------------------------
  // Bit counting within one byte slot
  // ----------------------------------------------------------------
  localparam logic [3:0] CNT_LSB = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_DONE = 4'h9;
  localparam logic [3:0] CNT_STEP = 4'h1;

  // ----------------------------------------------------------------
  // Timing: the port needs no speed setting, only enough core cycles
  // ----------------------------------------------------------------
  localparam int CORE_HZ = 50000000;
  localparam int SCL_MAX_HZ = 400000;
  localparam int CORE_PER_SCL = CORE_HZ / SCL_MAX_HZ;
  localparam logic SCL_IDLE_LVL = 1'b1; // Serial clock level on an idle bus

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_MPTR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } i2tp_state_t;

  typedef struct packed {
    logic [7:0] raddr;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic we;
  } i2tp_reg_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] rdata_lsb;
  } i2tp_reg_rsp_t;

  function automatic logic i2tp_writable(input logic [7:0] a);
    return (a == ADDR_STATUS) || (a == ADDR_ACC_HI) || (a == ADDR_ACC_LO) ||
           (a == ADDR_OFFS_BIAS) || (a == ADDR_ACC_BIAS);
  endfunction

  function automatic logic i2tp_pair_hi(input logic [7:0] a);
    return (a == ADDR_TEMP_HI) || (a == ADDR_VOLT_HI) || (a == ADDR_CURR_HI) ||
           (a == ADDR_ACC_HI);
  endfunction

endpackage

// ==== rtl/i2tp_target.sv ====
// Two-wire target port: serial-clock edge capture and core protocol engine
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Edge capture on the serial clock: one toggle and one sampled bit
// ------------------------------------------------------------------
module i2tp_edge_tgl (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sda_i,
  output logic tgl_o,
  output logic bit_o
);
  typedef struct packed {
    logic tgl;
    logic smp;
  } i2tp_edge_t;

  i2tp_edge_t edge_reg;
  i2tp_edge_t edge_next;

  // Toggle per edge; the data line is stable at a rising edge
  always_comb begin
    edge_next.tgl = ~edge_reg.tgl;
    edge_next.smp = sda_i;
  end

  // Async reset to constants only: the serial clock may be stopped in reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edge_reg <= '0;
    end else begin
      edge_reg <= edge_next;
    end
  end

  assign tgl_o = edge_reg.tgl;
  assign bit_o = edge_reg.smp;
endmodule

// ------------------------------------------------------------------
// Top: protocol engine in the core clock domain
// ------------------------------------------------------------------
module i2tp_target (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output i2tp_pkg::i2tp_reg_req_t REG_REQ_O,
  input wire i2tp_pkg::i2tp_reg_rsp_t REG_RSP_I,
  output logic [6:0] TGT_ADDR_O
);
  typedef struct packed {
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] flt;
    logic [2:0] fltd;
    logic [2:0] sdad;
    logic scl_high;
    i2tp_pkg::i2tp_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic [7:0] ptr;
    logic ovf;
    logic [7:0] wbuf;
    logic [7:0] waddr;
    logic wok;
    logic hack;
    logic drive;
    logic [2:0] tgt_low;
    logic [2:0] pend_low;
    logic lat_v;
    logic [7:0] lat_addr;
    logic [7:0] lat_lsb;
    i2tp_pkg::i2tp_reg_req_t req;
  } i2tp_core_t;

  i2tp_core_t core_reg;
  i2tp_core_t core_next;
  logic rise_tgl;
  logic fall_tgl;
  logic rise_bit;
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;

  // ----------------------------------------------------------------
  // Link-side capture, one instance per serial clock edge
  // ----------------------------------------------------------------
  i2tp_edge_tgl u_rise (
    .clk_i(SCL_I),
    .rstn_i(RSTN_I),
    .sda_i(SDA_I),
    .tgl_o(rise_tgl),
    .bit_o(rise_bit)
  );

  i2tp_edge_tgl u_fall (
    .clk_i(~SCL_I),
    .rstn_i(RSTN_I),
    .sda_i(SDA_I),
    .tgl_o(fall_tgl),
    .bit_o()
  );

  // Events from the filtered sync outputs; data line is delayed further so
  // a change right after a clock fall is never mistaken for start or stop
  assign rise_ev = core_reg.flt[1] ^ core_reg.fltd[1];
  assign fall_ev = core_reg.flt[2] ^ core_reg.fltd[2];
  assign start_ev = core_reg.scl_high & core_reg.sdad[2] & ~core_reg.sdad[1];
  assign stop_ev = core_reg.scl_high & ~core_reg.sdad[2] & core_reg.sdad[1];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] byte_in;
    logic [7:0] byte_out;
    byte_in = {core_reg.sh[6:0], rise_bit};
    byte_out = i2tp_pkg::FILL_BYTE;
    core_next = core_reg;
    core_next.req.we = 1'b0;
    // Three-stage sync, a change counts when stages two and three agree
    core_next.sy1 = {fall_tgl, rise_tgl, SDA_I};
    core_next.sy2 = core_reg.sy1;
    core_next.sy3 = core_reg.sy2;
    core_next.flt = (~(core_reg.sy2 ^ core_reg.sy3) & core_reg.sy3) |
                    ((core_reg.sy2 ^ core_reg.sy3) & core_reg.flt);
    core_next.fltd = core_reg.flt;
    core_next.sdad = {core_reg.sdad[1:0], core_reg.flt[0]};
    if (rise_ev) begin
      core_next.scl_high = 1'b1;
    end
    if (fall_ev) begin
      core_next.scl_high = 1'b0;
    end

    if (stop_ev) begin
      core_next.st = i2tp_pkg::ST_IDLE;
      core_next.drive = 1'b0;
      core_next.lat_v = 1'b0;
    end else if (start_ev) begin
      core_next.st = i2tp_pkg::ST_ADDR;
      core_next.cnt = '0;
      core_next.drive = 1'b0;
      core_next.lat_v = 1'b0;
      core_next.tgt_low = core_reg.pend_low;
    end else if (core_reg.st != i2tp_pkg::ST_IDLE && rise_ev) begin
      if (core_reg.cnt < i2tp_pkg::CNT_ACK) begin
        // Outgoing bytes shift on falls, incoming ones on rises
        if (core_reg.st != i2tp_pkg::ST_RDATA) begin
          core_next.sh = byte_in;
        end
        core_next.cnt = core_reg.cnt + i2tp_pkg::CNT_STEP;
        if (core_reg.cnt == i2tp_pkg::CNT_LSB) begin
          unique case (core_reg.st)
            i2tp_pkg::ST_ADDR: begin
              if (byte_in[7:1] == {i2tp_pkg::SA_HI, core_reg.tgt_low}) begin
                core_next.rd = byte_in[0];
              end else begin
                core_next.st = i2tp_pkg::ST_IDLE;
              end
            end
            i2tp_pkg::ST_MPTR: begin
              core_next.ptr = byte_in;
              core_next.ovf = 1'b0;
            end
            i2tp_pkg::ST_WDATA: begin
              core_next.wbuf = byte_in;
              core_next.waddr = core_reg.ptr;
              core_next.wok = ~core_reg.ovf & i2tp_pkg::i2tp_writable(core_reg.ptr);
              core_next.ptr = core_reg.ptr + i2tp_pkg::PTR_STEP;
              core_next.ovf = core_reg.ovf | (core_reg.ptr == i2tp_pkg::ADDR_LAST);
            end
            i2tp_pkg::ST_RDATA: begin
              core_next.ptr = core_reg.ptr + i2tp_pkg::PTR_STEP;
              core_next.ovf = core_reg.ovf | (core_reg.ptr == i2tp_pkg::ADDR_LAST);
            end
            default: begin
              core_next.st = i2tp_pkg::ST_IDLE;
            end
          endcase
        end
      end else if (core_reg.cnt == i2tp_pkg::CNT_ACK) begin
        // Ninth rise: commit only now, so a cut-short slot stores nothing
        core_next.cnt = i2tp_pkg::CNT_DONE;
        core_next.hack = ~rise_bit;
        if (core_reg.st == i2tp_pkg::ST_WDATA && core_reg.wok) begin
          core_next.req.we = 1'b1;
          core_next.req.waddr = core_reg.waddr;
          core_next.req.wdata = core_reg.wbuf;
          if (core_reg.waddr == i2tp_pkg::ADDR_STATUS) begin
            core_next.pend_low = core_reg.wbuf[2:0];
          end
        end
      end
    end else if (core_reg.st != i2tp_pkg::ST_IDLE && fall_ev) begin
      if (core_reg.cnt == i2tp_pkg::CNT_ACK) begin
        // Acknowledge every byte we receive; release for the host's turn
        core_next.drive = (core_reg.st != i2tp_pkg::ST_RDATA);
      end else if (core_reg.cnt == i2tp_pkg::CNT_DONE) begin
        core_next.cnt = '0;
        core_next.drive = 1'b0;
        unique case (core_reg.st)
          i2tp_pkg::ST_ADDR: begin
            core_next.st = core_reg.rd ? i2tp_pkg::ST_RDATA : i2tp_pkg::ST_MPTR;
          end
          i2tp_pkg::ST_MPTR: begin
            core_next.st = i2tp_pkg::ST_WDATA;
          end
          i2tp_pkg::ST_WDATA: begin
            core_next.st = i2tp_pkg::ST_WDATA;
          end
          i2tp_pkg::ST_RDATA: begin
            core_next.st = core_reg.hack ? i2tp_pkg::ST_RDATA : i2tp_pkg::ST_IDLE;
          end
          default: begin
            core_next.st = i2tp_pkg::ST_IDLE;
          end
        endcase
        if (core_next.st == i2tp_pkg::ST_RDATA) begin
          // Load next byte; a latched low half wins over live data
          if (core_reg.ovf) begin
            byte_out = i2tp_pkg::FILL_BYTE;
          end else if (core_reg.lat_v && core_reg.lat_addr == core_reg.ptr) begin
            byte_out = core_reg.lat_lsb;
          end else begin
            byte_out = REG_RSP_I.rdata;
          end
          if (!core_reg.ovf && i2tp_pkg::i2tp_pair_hi(core_reg.ptr)) begin
            core_next.lat_v = 1'b1;
            core_next.lat_addr = core_reg.ptr + i2tp_pkg::PTR_STEP;
            core_next.lat_lsb = REG_RSP_I.rdata_lsb;
          end
          core_next.sh = byte_out;
          core_next.drive = ~byte_out[7];
        end
      end else if (core_reg.st == i2tp_pkg::ST_RDATA && core_reg.cnt != '0) begin
        core_next.sh = {core_reg.sh[6:0], 1'b0};
        core_next.drive = ~core_reg.sh[6];
      end
    end
    core_next.req.raddr = core_next.ptr;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      core_reg <= '0;
      core_reg.tgt_low <= i2tp_pkg::SA_LO_RST;
      core_reg.pend_low <= i2tp_pkg::SA_LO_RST;
      // Clock idles high; a low reset value would hide the first start
      core_reg.scl_high <= i2tp_pkg::SCL_IDLE_LVL;
    end else begin
      core_reg <= core_next;
    end
  end

  // Open-drain: only ever pull low
  assign SDA_O = 1'b0;
  assign SDA_OE_O = core_reg.drive;
  assign REG_REQ_O = core_reg.req;
  assign TGT_ADDR_O = {i2tp_pkg::SA_HI, core_reg.tgt_low};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  AST_RESET_ADDR: assert property ($rose(RSTN_I) |-> TGT_ADDR_O == 7'h48)
    else $error("Target address not at default after reset");
  AST_FIXED_HI: assert property (TGT_ADDR_O[6:3] == i2tp_pkg::SA_HI)
    else $error("Upper target address bits changed");
  AST_ADDR_ON_START: assert property ($changed(core_reg.tgt_low) |-> $past(start_ev))
    else $error("Target address changed outside a start");
  AST_WRITE_LEGAL: assert property (REG_REQ_O.we |->
      i2tp_pkg::i2tp_writable(REG_REQ_O.waddr))
    else $error("Write to read-only or reserved address");
  AST_COMMIT_AT_ACK: assert property (REG_REQ_O.we |->
      $past(rise_ev && core_reg.cnt == i2tp_pkg::CNT_ACK))
    else $error("Write committed outside the acknowledge rise");
  AST_IDLE_RELEASED: assert property (core_reg.st == i2tp_pkg::ST_IDLE |-> !SDA_OE_O)
    else $error("Data line driven while idle");
  AST_ADDR_ACK: assert property (fall_ev && core_reg.cnt == i2tp_pkg::CNT_ACK &&
      core_reg.st == i2tp_pkg::ST_ADDR |=> SDA_OE_O)
    else $error("Matching address not acknowledged");
  AST_WPTR_STEP: assert property (rise_ev && core_reg.cnt == i2tp_pkg::CNT_LSB &&
      core_reg.st == i2tp_pkg::ST_WDATA |=>
      core_reg.ptr == $past(core_reg.ptr) + i2tp_pkg::PTR_STEP)
    else $error("Pointer did not advance after written byte");
  AST_FILL_PAST_END: assert property (core_reg.st == i2tp_pkg::ST_RDATA && fall_ev &&
      core_reg.cnt == i2tp_pkg::CNT_DONE && core_reg.ovf && core_reg.hack |=>
      core_reg.sh == i2tp_pkg::FILL_BYTE)
    else $error("Read past end did not return fill byte");
  AST_MSB_DRIVEN: assert property (core_reg.st == i2tp_pkg::ST_RDATA && fall_ev &&
      core_reg.cnt == i2tp_pkg::CNT_DONE && core_reg.hack |=> SDA_OE_O == ~core_reg.sh[7])
    else $error("Read byte msb not placed on the line");
endmodule

`default_nettype wire

// ==== sim/i2tp_ctl_model.sv ====
// Two-wire bus controller model: drives the serial clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none

module i2tp_ctl_model (
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  // ------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------
  // Quarter period of a 400kHz clock, the fastest the port must handle
  localparam time QTR = 625ns;

  // Idle: clock high, data released so the pull-up wins
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_oe_o = 1'b0;
    #QTR;
    scl_o = 1'b1;
    #QTR;
    sda_oe_o = 1'b1;
    #QTR;
    scl_o = 1'b0;
    #QTR;
  endtask

  // Stop: data rises while the clock is high, then the clock stands still
  task automatic stop_cond();
    sda_oe_o = 1'b1;
    #QTR;
    scl_o = 1'b1;
    #QTR;
    sda_oe_o = 1'b0;
    #QTR;
  endtask

  // One bit: data changes only while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    sda_oe_o = ~b;
    #QTR;
    scl_o = 1'b1;
    #QTR;
    s = sda_i;
    #QTR;
    scl_o = 1'b0;
    #QTR;
  endtask

  // A byte msb first, then the acknowledge slot; a 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic s);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(a, s);
  endtask
endmodule
`default_nettype wire

// ==== sim/test_i2tp_target.sv ====
// Self-checking bench for the two-wire target port
`timescale 1ns/1ps
`default_nettype none

module test_i2tp_target;
  logic core_clk;
  logic rstn;
  logic scl;
  logic sda_oe_ctl;
  logic sda_o;
  logic sda_oe_dev;
  wire logic sda;
  logic [6:0] tgt_addr;
  logic [7:0] salt;
  i2tp_pkg::i2tp_reg_req_t reg_req;
  i2tp_pkg::i2tp_reg_rsp_t reg_rsp;
  logic [15:0] wlog[$];
  int fails;
  int total_checks;

  // Open-drain line: controller pulls low, device shows its data pin when enabled,
  // else the pull-up; a device pin stuck high would then show on the wire
  assign sda = sda_oe_ctl ? 1'b0 : (sda_oe_dev ? sda_o : 1'b1);
  // Register space stand-in; the salt lets a stale latched byte show
  assign reg_rsp = {reg_req.raddr ^ salt, (reg_req.raddr + 8'h01) ^ salt};

  i2tp_target i2tp_target_inst (.CORE_CLK_I(core_clk), .RSTN_I(rstn), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe_dev), .REG_REQ_O(reg_req),
    .REG_RSP_I(reg_rsp), .TGT_ADDR_O(tgt_addr));
  i2tp_ctl_model i2tp_ctl_model_inst (.scl_o(scl), .sda_oe_o(sda_oe_ctl), .sda_i(sda));

  // Core clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Record every committed register write
  always @(posedge core_clk) begin
    if (reg_req.we === 1'b1) begin
      wlog.push_back({reg_req.waddr, reg_req.wdata});
    end
  end

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Byte to the device; an acknowledge shows as a low level in slot nine
  task automatic send(input logic [7:0] d, input logic ack, input string name);
    logic [7:0] q;
    logic s;
    i2tp_ctl_model_inst.xfer(d, 1'b1, q, s);
    chk(name, {15'h0, s}, {15'h0, ~ack});
  endtask

  // Byte from the device, answered with acknowledge or not
  task automatic recv(input logic nack, input logic [7:0] exp, input string name);
    logic [7:0] q;
    logic s;
    i2tp_ctl_model_inst.xfer(8'hff, nack, q, s);
    chk(name, {8'h0, q}, {8'h0, exp});
  endtask

  // Start, own address for writing, then the pointer byte
  task automatic hdr(input logic [7:0] ptr);
    i2tp_ctl_model_inst.start_cond();
    send(8'h90, 1'b1, "addr_wr");
    send(ptr, 1'b1, "ptr");
  endtask

  // Compare the write record with up to two expected entries, then clear it
  task automatic log_is(input int n, input logic [15:0] e0, input logic [15:0] e1);
    chk("wr_count", 16'(wlog.size()), 16'(n));
    if (n > 0) chk("wr0", wlog[0], e0);
    if (n > 1) chk("wr1", wlog[1], e1);
    wlog.delete();
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("tgt_addr", {9'h0, tgt_addr}, 16'h0048);
    chk("sda_oe", {15'h0, sda_oe_dev}, 16'h0000);
    chk("sda_o", {15'h0, sda_o}, 16'h0000);
  endtask

  task automatic t_probe();
    i2tp_ctl_model_inst.start_cond();
    send(8'h94, 1'b0, "probe_other");
    i2tp_ctl_model_inst.stop_cond();
    i2tp_ctl_model_inst.start_cond();
    send(8'h90, 1'b1, "probe_own");
    i2tp_ctl_model_inst.stop_cond();
  endtask

  // Run over two writable bytes into a reserved one, which is acked but dropped
  task automatic t_write_run();
    hdr(8'h61);
    send(8'h3c, 1'b1, "wd0");
    send(8'h5b, 1'b1, "wd1");
    send(8'h77, 1'b1, "wd2");
    i2tp_ctl_model_inst.stop_cond();
    log_is(2, 16'h613c, 16'h625b);
  endtask

  // A byte cut short by a stop after four bits must not land
  task automatic t_cut();
    logic s;
    hdr(8'h10);
    send(8'ha1, 1'b1, "wd_full");
    for (int i = 0; i < 4; i++) i2tp_ctl_model_inst.clk_bit(i[0], s);
    i2tp_ctl_model_inst.stop_cond();
    log_is(1, 16'h10a1, 16'h0000);
  endtask

  // The third byte wraps onto a writable address and must still be dropped
  task automatic t_past_end_write();
    hdr(8'hff);
    send(8'h11, 1'b1, "wd_ff");
    send(8'h22, 1'b1, "wd_past");
    send(8'h40, 1'b1, "wd_wrap");
    i2tp_ctl_model_inst.stop_cond();
    log_is(0, 16'h0000, 16'h0000);
  endtask

  // Low byte must come from the latch even though the source changed
  task automatic t_read_pair();
    @(posedge core_clk);
    salt <= 8'h00;
    hdr(8'h0a);
    i2tp_ctl_model_inst.start_cond();
    send(8'h91, 1'b1, "addr_rd");
    // High byte is already loaded; change the source before the low byte loads
    @(posedge core_clk);
    salt <= 8'h33;
    recv(1'b0, 8'h0a, "rd_hi");
    recv(1'b1, 8'h0b, "rd_lo");
    chk("sda_rel", {15'h0, sda_oe_dev}, 16'h0000);
    i2tp_ctl_model_inst.stop_cond();
  endtask

  task automatic t_read_past_end();
    hdr(8'hff);
    i2tp_ctl_model_inst.start_cond();
    send(8'h91, 1'b1, "addr_rd");
    recv(1'b0, 8'hcc, "rd_ff");
    recv(1'b0, 8'hff, "rd_past0");
    recv(1'b1, 8'hff, "rd_past1");
    chk("sda_rel", {15'h0, sda_oe_dev}, 16'h0000);
    i2tp_ctl_model_inst.stop_cond();
  endtask

  // New low address bits apply from the next repeated start; upper bits stay
  task automatic t_addr_change();
    hdr(8'h01);
    send(8'hfd, 1'b1, "wd_status");
    chk("tgt_hold", {9'h0, tgt_addr}, 16'h0048);
    i2tp_ctl_model_inst.start_cond();
    send(8'h9a, 1'b1, "new_addr");
    i2tp_ctl_model_inst.stop_cond();
    chk("tgt_new", {9'h0, tgt_addr}, 16'h004d);
    log_is(1, 16'h01fd, 16'h0000);
    i2tp_ctl_model_inst.start_cond();
    send(8'h90, 1'b0, "old_addr");
    i2tp_ctl_model_inst.stop_cond();
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    salt = 8'h00;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge core_clk);
    t_reset();
    t_probe();
    t_write_run();
    t_cut();
    t_past_end_write();
    t_read_pair();
    t_read_past_end();
    t_addr_change();
    print_verdict();
  end

  // Watchdog: the sequence needs about 0.75 ms of bus time
  initial begin
    #1500us;
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
